// ==== rtl/ppl_device.sv ====
// Device end: status and done handshake, word capture on the load clock
`timescale 1ns/1ps
module ppl_device
    import ppl_pkg::*;
#(
    parameter int WORDS      = CONFIG_WORDS,
    parameter int STATUS_CYC = STATUS_LOW_CYC,
    parameter int INIT_WAIT  = INIT_CYC
) (
    ppl_link_if.device        link,
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              wide16,
    input  wire logic              encrypt,
    input  wire logic              compress,
    output logic [DATA_W-1:0]      cfg_word,
    output logic                   cfg_word_valid,
    output logic                   user_mode
);
    typedef enum logic [5:0] {
        D_HOLD   = 6'h01,
        D_STATUS = 6'h02,
        D_WAIT   = 6'h04,
        D_LOAD   = 6'h08,
        D_INIT   = 6'h10,
        D_USER   = 6'h20
    } dev_state_t;

    dev_state_t        state;
    cnt_t              cnt;
    cnt_t              word_cnt;
    logic [2:0]        s1;
    logic [2:0]        s2;
    logic [2:0]        s3;
    logic [2:0]        q;
    logic              tgl_prev;
    logic              load_en;
    logic              load_rst_n;
    ratio_t            ratio;
    ratio_t            phase;
    logic              word_tgl;
    logic [DATA_W-1:0] word_reg;
    logic              req_q;
    logic              line_q;
    logic              word_evt;

    assign ratio      = load_ratio(wide16, encrypt, compress);
    assign req_q      = q[0];
    assign line_q     = q[1];
    assign word_evt   = q[2] ^ tgl_prev;
    assign load_rst_n = rst_n & load_en;

    // Pin and toggle synchronisers, rise taken when stages two and three agree, fall taken as soon as they differ
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1       <= 3'h5;
            s2       <= 3'h5;
            s3       <= 3'h5;
            q        <= 3'h5;
            tgl_prev <= 1'b1;
        end else begin
            s1       <= {word_tgl, link.status_n, link.config_req_n};
            s2       <= s1;
            s3       <= s2;
            q        <= (s2 & s3) | (q & ~(s2 ^ s3));
            tgl_prev <= q[2];
        end
    end

    // sample on rising load clock, first edge of each word
    always_ff @(posedge link.load_clock or negedge load_rst_n) begin
        if (!load_rst_n) begin
            phase    <= 3'h0;
            word_tgl <= 1'b1;
            word_reg <= 16'h0000;
        end else begin
            if (phase == 3'h0) begin
                word_reg <= wide16 ? link.data : {{(DATA_W-BYTE_W){1'b0}}, link.data[BYTE_W-1:0]};
                word_tgl <= ~word_tgl;
            end
            phase <= (phase == ratio - 3'h1) ? 3'h0 : phase + 3'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= D_HOLD;
            cnt      <= '0;
            word_cnt <= '0;
        end else if (!req_q) begin
            state    <= D_HOLD;
            cnt      <= '0;
            word_cnt <= '0;
        end else begin
            unique case (state)
                D_HOLD: begin
                    state <= D_STATUS;
                end
                D_STATUS: begin
                    cnt <= cnt + 32'h1;
                    if (cnt == cnt_t'(STATUS_CYC - 1)) begin
                        state <= D_WAIT;
                    end
                end
                D_WAIT: begin
                    cnt <= '0;
                    if (line_q) begin
                        state <= D_LOAD;
                    end
                end
                D_LOAD: begin
                    if (word_evt) begin
                        word_cnt <= word_cnt + 32'h1;
                        if (word_cnt == cnt_t'(WORDS - 1)) begin
                            state <= D_INIT;
                        end
                    end
                end
                D_INIT: begin
                    cnt <= cnt + 32'h1;
                    if (cnt == cnt_t'(INIT_WAIT - 1)) begin
                        state <= D_USER;
                    end
                end
                D_USER: begin
                    state <= D_USER;
                end
            endcase
        end
    end

    // status low on request, done low on request
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link.status_oe <= 1'b1;
            link.done_oe   <= 1'b1;
            load_en        <= 1'b0;
            user_mode      <= 1'b0;
        end else begin
            link.status_oe <= !req_q || state == D_HOLD || (state == D_STATUS && cnt != cnt_t'(STATUS_CYC - 1));
            link.done_oe   <= !req_q || !(state == D_INIT || state == D_USER ||
                              (state == D_LOAD && word_evt && word_cnt == cnt_t'(WORDS - 1)));
            load_en        <= req_q && state == D_LOAD;
            user_mode      <= req_q && state == D_INIT && cnt == cnt_t'(INIT_WAIT - 1) || req_q && state == D_USER;
        end
    end

    // Words handed to user side
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_word       <= 16'h0000;
            cfg_word_valid <= 1'b0;
        end else begin
            cfg_word_valid <= req_q && state == D_LOAD && word_evt;
            if (word_evt) begin
                cfg_word <= word_reg;
            end
        end
    end
endmodule

// ==== rtl/ppl_host.sv ====
// Host end: request pulse, status wait, load clock divider and word streaming
`timescale 1ns/1ps
module ppl_host
    import ppl_pkg::*;
#(
    parameter int DIV_HALF    = LOAD_HALF_CYC,
    parameter int REQ_CYC     = REQ_LOW_CYC,
    parameter int BLIND_CYC   = REQ_TO_CLK_CYC,
    parameter int GAP_CYC     = STAT_TO_CLK_CYC
) (
    ppl_link_if.host              link,
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [REG_AW-1:0] reg_addr,
    input  wire logic [REG_DW-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [REG_DW-1:0]      reg_rdata
);
    typedef enum logic [5:0] {
        H_IDLE   = 6'h01,
        H_REQ    = 6'h02,
        H_WAIT   = 6'h04,
        H_GAP    = 6'h08,
        H_STREAM = 6'h10,
        H_DONE   = 6'h20
    } host_state_t;
    // divider never faster than the load clock limit
    localparam int HALF = (DIV_HALF < LOAD_HALF_MIN_CYC) ? LOAD_HALF_MIN_CYC : DIV_HALF;
    host_state_t       state;
    cnt_t              cnt;
    cnt_t              div_cnt;
    cnt_t              word_total;
    logic [1:0]        s1;
    logic [1:0]        s2;
    logic [1:0]        s3;
    logic [1:0]        q;
    logic              status_q;
    logic              done_q;
    logic              mode_wide;
    logic              mode_enc;
    logic              mode_comp;
    logic              mode_mon;
    ratio_t            ratio;
    ratio_t            edge_cnt;
    logic [DATA_W-1:0] hold;
    logic              hold_full;
    logic              word_live;
    logic              clk_hi;
    logic              tick;
    logic              consume;
    logic              err;
    logic              err_set;
    logic              fin;
    logic              start_wr;
    logic              restart;
    assign status_q = q[0];
    assign done_q   = q[1];
    assign tick     = (div_cnt == cnt_t'(HALF - 1));
    assign start_wr = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_START] && (state == H_IDLE || state == H_DONE);
    // status fall while loading forces restart
    assign restart  = mode_mon && !status_q && (state == H_GAP || state == H_STREAM);
    assign err_set  = restart;
    assign consume  = state == H_STREAM && tick && !clk_hi && !word_live && hold_full && !done_q;
    // Line synchronisers, rise taken when stages two and three agree, fall taken as soon as they differ
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 2'h0;
            s2 <= 2'h0;
            s3 <= 2'h0;
            q  <= 2'h0;
        end else begin
            s1 <= {link.done, link.status_n};
            s2 <= s1;
            s3 <= s2;
            q  <= (s2 & s3) | (q & ~(s2 ^ s3));
        end
    end

    // Mode latched at start
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_wide <= 1'b0;
            mode_enc  <= 1'b0;
            mode_comp <= 1'b0;
            mode_mon  <= 1'b0;
            ratio     <= RATIO_ONE;
        end else if (reg_wr && reg_addr == REG_CTRL && (state == H_IDLE || state == H_DONE)) begin
            mode_wide <= reg_wdata[CTRL_WIDE];
            mode_enc  <= reg_wdata[CTRL_ENC];
            mode_comp <= reg_wdata[CTRL_COMP];
            mode_mon  <= reg_wdata[CTRL_MON];
            ratio     <= load_ratio(reg_wdata[CTRL_WIDE], reg_wdata[CTRL_ENC], reg_wdata[CTRL_COMP]);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= H_IDLE;
            cnt   <= '0;
        end else if (restart) begin
            state <= H_REQ;
            cnt   <= '0;
        end else begin
            unique case (state)
                H_IDLE: begin
                    if (start_wr) begin
                        state <= H_REQ;
                        cnt   <= '0;
                    end
                end
                H_REQ: begin
                    cnt <= cnt + 32'h1;
                    if (cnt == cnt_t'(REQ_CYC - 1)) begin
                        state <= H_WAIT;
                        cnt   <= '0;
                    end
                end
                H_WAIT: begin
                    if (mode_mon) begin
                        if (status_q) begin
                            state <= H_GAP;
                            cnt   <= '0;
                        end
                    end else begin
                        cnt <= cnt + 32'h1;
                        if (cnt == cnt_t'(BLIND_CYC - 1)) begin
                            state <= H_STREAM;
                        end
                    end
                end
                H_GAP: begin
                    cnt <= cnt + 32'h1;
                    if (cnt == cnt_t'(GAP_CYC - 1)) begin
                        state <= H_STREAM;
                    end
                end
                H_STREAM: begin
                    if (done_q && !clk_hi && !word_live) begin
                        state <= H_DONE;
                    end
                end
                H_DONE: begin
                    if (start_wr) begin
                        state <= H_REQ;
                        cnt   <= '0;
                    end
                end
            endcase
        end
    end

    // Request pin
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link.config_req_n <= 1'b1;
        end else begin
            link.config_req_n <= !(restart || (state == H_IDLE && start_wr) || (state == H_DONE && start_wr) ||
                                   (state == H_REQ && cnt != cnt_t'(REQ_CYC - 1)));
        end
    end

    // load clock divider, ratio edges per word
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt   <= '0;
            clk_hi    <= 1'b0;
            edge_cnt  <= 3'h0;
            word_live <= 1'b0;
            link.data <= 16'h0000;
        end else if (state != H_STREAM || restart) begin
            div_cnt   <= '0;
            clk_hi    <= 1'b0;
            edge_cnt  <= 3'h0;
            word_live <= 1'b0;
        end else begin
            div_cnt <= tick ? '0 : div_cnt + 32'h1;
            if (tick) begin
                if (clk_hi) begin
                    clk_hi <= 1'b0;
                    // data held until last edge of the word
                    if (edge_cnt == ratio - 3'h1) begin
                        edge_cnt  <= 3'h0;
                        word_live <= 1'b0;
                    end else begin
                        edge_cnt <= edge_cnt + 3'h1;
                    end
                end else if (word_live) begin
                    clk_hi <= 1'b1;
                end else if (consume) begin
                    link.data <= mode_wide ? hold : {{(DATA_W-BYTE_W){1'b0}}, hold[BYTE_W-1:0]};
                    word_live <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link.load_clock <= 1'b0;
        end else begin
            link.load_clock <= clk_hi;
        end
    end

    // Holding register, writes refused while full
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hold      <= 16'h0000;
            hold_full <= 1'b0;
        end else if (consume) begin
            hold_full <= 1'b0;
        end else if (reg_wr && reg_addr == REG_DATA && !hold_full) begin
            hold      <= reg_wdata[DATA_W-1:0];
            hold_full <= 1'b1;
        end
    end

    // Sticky error, set wins over write-one clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            err        <= 1'b0;
            fin        <= 1'b0;
            word_total <= '0;
        end else begin
            if (err_set) begin
                err <= 1'b1;
            end else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STAT_ERR]) begin
                err <= 1'b0;
            end
            fin <= (state == H_DONE) || (state == H_STREAM && done_q && !clk_hi && !word_live);
            if (start_wr || restart) begin
                word_total <= '0;
            end else if (consume) begin
                word_total <= word_total + 32'h1;
            end
        end
    end

    // Register read port, data one cycle after the strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL:   reg_rdata <= REG_DW'({mode_mon, mode_comp, mode_enc, mode_wide, 1'b0});
                REG_STATUS: reg_rdata <= REG_DW'({state, 4'h0, hold_full, err, fin,
                                                  !(state == H_IDLE || state == H_DONE)});
                REG_COUNT:  reg_rdata <= word_total;
                default:    reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule

// ==== rtl/ppl_link_if.sv ====
// Link wires between configuration host and device
`timescale 1ns/1ps
interface ppl_link_if;
    import ppl_pkg::*;
    logic              config_req_n;
    logic              load_clock;
    logic [DATA_W-1:0] data;
    logic              status_oe;
    logic              done_oe;
    logic              status_n;
    logic              done;

    // Open-drain lines with pull-ups
    assign status_n = ~status_oe;
    assign done     = ~done_oe;

    modport device (
        input  config_req_n,
        input  load_clock,
        input  data,
        input  status_n,
        output status_oe,
        output done_oe
    );

    modport host (
        output config_req_n,
        output load_clock,
        output data,
        input  status_n,
        input  done
    );
endinterface

// ==== rtl/ppl_pkg.sv ====
// Shared constants, types and register map of the passive parallel configuration link
package ppl_pkg;
    // Clock, link and register port widths
    localparam int MCLK_NS    = 4;
    localparam int DATA_W     = 16;
    localparam int BYTE_W     = 8;
    localparam int REG_AW     = 8;
    localparam int REG_DW     = 32;

    // Link timing in printed units, with derived mclk counts
    localparam int T_REQ_LOW_MIN_NS     = 2000;
    localparam int REQ_LOW_CYC          = (T_REQ_LOW_MIN_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int T_ASSERT_MAX_NS      = 600;
    localparam int T_STATUS_LOW_MIN_US  = 268;
    localparam int T_STATUS_LOW_MAX_US  = 1506;
    localparam int STATUS_LOW_CYC       = (T_STATUS_LOW_MIN_US * 1000 + MCLK_NS - 1) / MCLK_NS;
    localparam int T_REQ_TO_CLK_MIN_US  = 1506;
    localparam int REQ_TO_CLK_CYC       = (T_REQ_TO_CLK_MIN_US * 1000 + MCLK_NS - 1) / MCLK_NS;
    localparam int T_STAT_TO_CLK_MIN_US = 2;
    localparam int STAT_TO_CLK_CYC      = (T_STAT_TO_CLK_MIN_US * 1000 + MCLK_NS - 1) / MCLK_NS;
    localparam int T_INIT_MIN_US        = 175;
    localparam int T_INIT_MAX_US        = 437;
    localparam int INIT_CYC             = (T_INIT_MIN_US * 1000 + MCLK_NS - 1) / MCLK_NS;
    localparam int LOAD_CLK_MAX_MHZ     = 125;
    localparam int LOAD_HALF_MIN_CYC    = (1000 + 2 * LOAD_CLK_MAX_MHZ * MCLK_NS - 1) / (2 * LOAD_CLK_MAX_MHZ * MCLK_NS);
    localparam int LOAD_HALF_CYC        = 4;
    localparam int CONFIG_WORDS         = 64;

    typedef logic [31:0] cnt_t;
    typedef logic [2:0]  ratio_t;

    localparam ratio_t RATIO_ONE  = 3'h1;
    localparam ratio_t RATIO_TWO  = 3'h2;
    localparam ratio_t RATIO_FOUR = 3'h4;

    // Load clock edges per data word
    function automatic ratio_t load_ratio(input logic wide, input logic enc, input logic comp);
        ratio_t r;
        r = RATIO_ONE;
        if (comp) begin
            r = wide ? RATIO_FOUR : RATIO_TWO;
        end else if (wide && enc) begin
            r = RATIO_TWO;
        end
        return r;
    endfunction

    // Host register map
    localparam logic [REG_AW-1:0] REG_CTRL   = 8'h00;
    localparam logic [REG_AW-1:0] REG_STATUS = 8'h04;
    localparam logic [REG_AW-1:0] REG_DATA   = 8'h08;
    localparam logic [REG_AW-1:0] REG_COUNT  = 8'h0C;

    localparam int CTRL_START = 0;
    localparam int CTRL_WIDE  = 1;
    localparam int CTRL_ENC   = 2;
    localparam int CTRL_COMP  = 3;
    localparam int CTRL_MON   = 4;

    localparam int STAT_BUSY  = 0;
    localparam int STAT_DONE  = 1;
    localparam int STAT_ERR   = 2;
    localparam int STAT_FULL  = 3;
    localparam int STAT_STATE = 8;
endpackage

// ==== sim/parallel_passive_config_load_tb.sv ====
// Self-checking bench joining the host and device ends of the load link
`timescale 1ns/1ps
module parallel_passive_config_load_tb;
    import ppl_pkg::*;
    localparam int REQ_C   = 20;
    localparam int STAT_C  = 50;
    localparam int GAP_C   = 10;
    localparam int BLIND_C = 200;
    localparam int INIT_W  = 40;
    localparam int NWORDS  = 8;

    logic              mclk;
    logic              rst_n;
    logic [REG_AW-1:0] reg_addr;
    logic [REG_DW-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [REG_DW-1:0] reg_rdata;
    logic              wide16;
    logic              encrypt;
    logic              compress;
    logic [DATA_W-1:0] cfg_word;
    logic              cfg_word_valid;
    logic              user_mode;
    int                num_errors;
    int                n_tests;
    int                n_rise;
    logic [DATA_W-1:0] got_q[$];
    int                rise_q[$];
    realtime           t_rel;
    realtime           t_first;
    realtime           t_done;
    realtime           t_um;

    ppl_link_if link();
    ppl_host #(.DIV_HALF(4), .REQ_CYC(REQ_C), .BLIND_CYC(BLIND_C), .GAP_CYC(GAP_C)) u_ppl_host (
        .link(link), .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    ppl_device #(.WORDS(NWORDS), .STATUS_CYC(STAT_C), .INIT_WAIT(INIT_W)) u_ppl_device (
        .link(link), .mclk(mclk), .rst_n(rst_n), .wide16(wide16), .encrypt(encrypt), .compress(compress),
        .cfg_word(cfg_word), .cfg_word_valid(cfg_word_valid), .user_mode(user_mode));
    ppl_asserts #(.REQ_CYC(REQ_C), .STATUS_CYC(STAT_C), .GAP_CYC(GAP_C)) u_ppl_asserts (
        .mclk(mclk), .rst_n(rst_n), .config_req_n(link.config_req_n), .load_clock(link.load_clock),
        .data(link.data), .status_oe(link.status_oe), .done_oe(link.done_oe));

    always #2 mclk = ~mclk;

    always @(posedge link.load_clock) begin
        if (n_rise == 0) begin
            t_first = $realtime;
        end
        n_rise++;
    end

    always @(posedge mclk) begin
        if (cfg_word_valid === 1'b1) begin
            got_q.push_back(cfg_word);
            rise_q.push_back(n_rise);
        end
    end

    always @(posedge link.config_req_n) t_rel = $realtime;
    always @(posedge link.done) t_done = $realtime;
    always @(posedge user_mode) t_um = $realtime;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [REG_AW-1:0] a, output logic [REG_DW-1:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Idle state after reset and an unmapped read
    task automatic check_idle();
        logic [REG_DW-1:0] s;
        rd(8'h10, s);
        chk(s, 32'h0);
        rd(REG_STATUS, s);
        chk({26'h0, s[13:8]}, 32'h1);
    endtask

    // One full load in the given mode, judged word by word
    task automatic run_load(input logic w, input logic e, input logic c, input logic mon);
        logic [REG_DW-1:0] s;
        logic [REG_DW-1:0] d;
        int                r;
        r = c ? (w ? 4 : 2) : ((w && e) ? 2 : 1);
        @(posedge mclk);
        wide16   <= w;
        encrypt  <= e;
        compress <= c;
        n_rise = 0;
        got_q.delete();
        rise_q.delete();
        wr(REG_CTRL, {27'h0, mon, c, e, w, 1'b1});
        rd(REG_CTRL, s);
        chk(s, {27'h0, mon, c, e, w, 1'b0});
        rd(REG_STATUS, s);
        chk(32'(s[STAT_BUSY]), 32'h1);
        for (int j = 0; j < NWORDS; j++) begin
            s = 32'h8;
            for (int k = 0; k < 400 && s[STAT_FULL] !== 1'b0; k++) rd(REG_STATUS, s);
            wr(REG_DATA, 32'h0000_A55A + j * 32'h0000_1357);
            // Write while full must be refused
            if (j == 0) begin
                wr(REG_DATA, 32'h0000_FFFF);
            end
        end
        s = 32'h0;
        for (int k = 0; k < 400 && s[STAT_DONE] !== 1'b1; k++) rd(REG_STATUS, s);
        chk({26'h0, s[13:8]}, 32'h20);
        chk(32'(s[3:0]), 32'h2);
        for (int k = 0; k < 300 && user_mode !== 1'b1; k++) @(posedge mclk);
        #1;
        chk(32'(user_mode), 32'h1);
        chk(32'(t_um - t_done >= INIT_W * 4 && t_um - t_done <= INIT_W * 4 * 437 / 175 + 40), 32'h1);
        if (!mon) begin
            chk(32'(t_first - t_rel >= BLIND_C * 4), 32'h1);
        end
        chk(got_q.size(), NWORDS);
        for (int j = 0; j < got_q.size(); j++) begin
            d = 32'h0000_A55A + j * 32'h0000_1357;
            chk({16'h0, got_q[j]}, w ? {16'h0, d[15:0]} : {24'h0, d[7:0]});
            if (j > 0) begin
                chk(rise_q[j] - rise_q[j - 1], r);
            end
        end
        rd(REG_COUNT, s);
        chk(s, NWORDS);
    endtask

    task automatic finish_test();
        $display("Checks: %0d, mismatches: %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        finish_test();
    end

    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        wide16 = 1'b0;
        encrypt = 1'b0;
        compress = 1'b0;
        num_errors = 0;
        n_tests = 0;
        n_rise = 0;
        repeat (12) @(posedge mclk);
        chk({link.config_req_n, link.load_clock, link.status_n, link.done}, 32'h8);
        rst_n <= 1'b1;
        check_idle();
        for (int i = 0; i < 8; i++) begin
            run_load(i[0], i[1], i[2], i[0] ^ i[1]);
        end
        finish_test();
    end
endmodule

// ==== sim/ppl_asserts.sv ====
// Concurrent checks on the wires of the passive parallel load link
`timescale 1ns/1ps
module ppl_asserts
    import ppl_pkg::*;
#(
    parameter int REQ_CYC    = REQ_LOW_CYC,
    parameter int STATUS_CYC = STATUS_LOW_CYC,
    parameter int GAP_CYC    = STAT_TO_CLK_CYC
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              config_req_n,
    input  wire logic              load_clock,
    input  wire logic [DATA_W-1:0] data,
    input  wire logic              status_oe,
    input  wire logic              done_oe
);
    // 600 ns in mclk cycles
    localparam int ASSERT_MAX = 150;
    localparam int REL_MAX    = STATUS_CYC + 16;

    cnt_t req_low_cnt;
    cnt_t stat_low_cnt;
    cnt_t stat_high_cnt;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            req_low_cnt <= '0;
        end else begin
            req_low_cnt <= config_req_n ? '0 : req_low_cnt + 1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stat_low_cnt <= '0;
        end else begin
            stat_low_cnt <= status_oe ? stat_low_cnt + 1 : '0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stat_high_cnt <= '0;
        end else begin
            stat_high_cnt <= status_oe ? '0 : stat_high_cnt + 1;
        end
    end

    a_status_fast: assert property ($fell(config_req_n) |-> ##[1:ASSERT_MAX] status_oe)
        else $error("status line not pulled low in time");
    a_done_fast: assert property ($fell(config_req_n) |-> ##[1:ASSERT_MAX] done_oe)
        else $error("done line not pulled low in time");
    a_status_cause: assert property ($rose(status_oe) |-> !config_req_n)
        else $error("status pulled low without a request");
    a_req_width: assert property ($rose(config_req_n) |-> req_low_cnt >= REQ_CYC)
        else $error("request pulse too short");
    a_status_min: assert property ($fell(status_oe) |-> stat_low_cnt >= STATUS_CYC)
        else $error("status low period too short");
    a_status_release: assert property ($rose(config_req_n) |-> ##[1:REL_MAX] !status_oe)
        else $error("status not released in time");
    a_first_gap: assert property ($rose(load_clock) |-> stat_high_cnt >= GAP_CYC)
        else $error("load clock edge too soon after status high");
    a_clk_high: assert property ($rose(load_clock) |-> load_clock [*4] ##1 !load_clock)
        else $error("load clock high time wrong");
    a_clk_low: assert property ($fell(load_clock) |-> !load_clock [*4])
        else $error("load clock low time too short");
    a_data_stable: assert property (load_clock |-> $stable(data))
        else $error("data moved while load clock high");

    c_req: cover property ($rose(config_req_n));
    c_clk: cover property ($rose(load_clock));
    c_done: cover property ($fell(done_oe));
endmodule
